// *** hdl/shp_pkg.sv ***
// shared constants and types for the serial host port and its command queue
// assumes a 25 MHz core clock and a host that masters the serial link
package shp_pkg;

  // command queue geometry
  localparam int unsigned QUEUE_BYTES = 4096;
  localparam int unsigned QUEUE_AW    = 12;

  // memory map, 22-bit byte addresses
  localparam logic [21:0] QUEUE_BASE     = 22'h100000;
  localparam logic [21:0] REG_CMD_READ   = 22'h200000;
  localparam logic [21:0] REG_CMD_WRITE  = 22'h200004;
  localparam logic [21:0] REG_LANE_WIDTH = 22'h200008;
  localparam logic [21:0] REG_INT_FLAGS  = 22'h20000c;

  // transaction header field, top two bits of the first address byte
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h2;

  // header bytes, then one dummy byte before read data
  localparam logic [2:0] IDX_ADDR_LAST = 3'h2;
  localparam logic [2:0] IDX_DATA      = 3'h4;

  // lane width select codes
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL   = 2'h1,
    LANE_QUAD   = 2'h2,
    LANE_RSVD   = 2'h3
  } lane_width_type;
  localparam logic [1:0] LANE_WIDTH_RST = 2'h0;

  // queue command that raises the host interrupt after a delay in ms
  localparam logic [31:0] CMD_TIMED_IRQ = 32'hffff_ff01;
  localparam logic [11:0] CMD_BYTES     = 12'h004;
  localparam logic [11:0] CMD_ARG_BYTES = 12'h008;

  // millisecond tick
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MS_TIME_NS    = 1000000;
  localparam int unsigned MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

  // host-side serial clock ceilings, for reference
  localparam int unsigned SCK_MAX_SD_HZ = 30000000;
  localparam int unsigned SCK_MAX_Q_HZ  = 25000000;

  // byte port request into the queue memory
  typedef struct packed {
    logic                we;
    logic [QUEUE_AW-1:0] addr;
    logic [7:0]          wdata;
  } mem_req_type;

endpackage

// *** hdl/shp_queue_ram.sv ***
// byte-wide two-port memory holding the command queue
// port a serves the host side (read or write), port b the engine (read)
`timescale 1ns/1ps
module shp_queue_ram #(
  parameter int unsigned AW = shp_pkg::QUEUE_AW
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // host port
  input  wire shp_pkg::mem_req_type req_a,
  output logic [7:0]                rdata_a,
  // engine port
  input  wire logic [AW-1:0]        addr_b,
  output logic [7:0]                rdata_b
);

  logic [7:0] mem [0:(1<<AW)-1];

  // storage, no reset on the array itself
  always_ff @(posedge clk) begin
    if (req_a.we) begin
      mem[req_a.addr] <= req_a.wdata;
    end
  end

  // registered read data on both ports
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_a <= 8'h00;
      rdata_b <= 8'h00;
    end else begin
      rdata_a <= mem[req_a.addr];
      rdata_b <= mem[addr_b];
    end
  end

endmodule // shp_queue_ram

// *** hdl/serial_host_port.sv ***
// serial host port with lane width select, command queue and queue engine
// assumes SCK, CS_N and lane inputs are asynchronous and much slower than CLK
`timescale 1ns/1ps
module serial_host_port #(
  parameter int unsigned MS_CYCLES = shp_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // serial link from host
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic [3:0] DATA_LANE_IN,
  output logic      [3:0] DATA_LANE_OUT,
  output logic      [3:0] DATA_LANE_OE_N,
  // interrupt to host
  output logic            INT_N
);

  typedef enum {E_IDLE, E_FETCH, E_DECODE, E_WAIT} eng_state_type;

  logic [2:0]  sck_s_ff;
  logic [2:0]  cs_s_ff;
  logic [3:0]  din1_ff;
  logic [3:0]  din2_ff;
  logic        sel;
  logic        rise;
  logic        fall;
  logic        cs_fall;
  logic [1:0]  lane_width_ff;
  logic [1:0]  width_ff;
  logic [3:0]  step;
  logic [2:0]  bitcnt_ff;
  logic [3:0]  cnt_sum;
  logic [7:0]  shift_ff;
  logic [7:0]  nxt_rx;
  logic        byte_done;
  logic [2:0]  idx_ff;
  logic [1:0]  op_ff;
  logic [21:0] addr_ff;
  logic        wr_now;
  logic        fetch_ff;
  logic        fetch2_ff;
  logic        src_q_ff;
  logic [7:0]  reg_byte_ff;
  logic [7:0]  nxt_byte_ff;
  logic [7:0]  hold_ff;
  logic [7:0]  tx_ff;
  logic        pend_ff;
  logic [3:0]  out_ff;
  logic        in_queue;
  logic [31:0] reg_word;
  logic [7:0]  reg_byte;
  logic [11:0] cmd_rd_ff;
  logic [11:0] cmd_wr_ff;
  logic        irq_flag_ff;
  logic        irq_set;
  logic        irq_clr;
  eng_state_type estate_ff;
  logic [11:0] fo_ff;
  logic [2:0]  k_ff;
  logic        arg_ff;
  logic [31:0] word_ff;
  logic [31:0] ms_left_ff;
  logic [31:0] cyc_ff;
  logic [11:0] avail;
  logic [7:0]  rdata_a;
  logic [7:0]  rdata_b;
  shp_pkg::mem_req_type req_a;

  // two-stage synchronisers plus one history stage for edge finding
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sck_s_ff <= 3'h0;
      cs_s_ff  <= 3'h7;
      din1_ff  <= 4'h0;
      din2_ff  <= 4'h0;
    end else begin
      sck_s_ff <= {sck_s_ff[1:0], SCK};
      cs_s_ff  <= {cs_s_ff[1:0], CS_N};
      din1_ff  <= DATA_LANE_IN;
      din2_ff  <= din1_ff;
    end
  end

  // link events seen in the core domain
  assign sel     = ~cs_s_ff[1];
  assign cs_fall = ~cs_s_ff[1] & cs_s_ff[2];
  assign rise    = sel & sck_s_ff[1] & ~sck_s_ff[2];
  assign fall    = sel & ~sck_s_ff[1] & sck_s_ff[2];

  // bits moved per serial clock for the active width
  always_comb begin
    case (width_ff)
      shp_pkg::LANE_DUAL: step = 4'h2;
      shp_pkg::LANE_QUAD: step = 4'h4;
      default:            step = 4'h1;
    endcase
  end

  // receive shift, lane 0 is MOSI in single mode
  always_comb begin
    case (width_ff)
      shp_pkg::LANE_DUAL: nxt_rx = {shift_ff[5:0], din2_ff[1:0]};
      shp_pkg::LANE_QUAD: nxt_rx = {shift_ff[3:0], din2_ff[3:0]};
      default:            nxt_rx = {shift_ff[6:0], din2_ff[0]};
    endcase
  end

  assign cnt_sum   = {1'b0, bitcnt_ff} + step;
  assign byte_done = rise & (cnt_sum == 4'h8);
  assign wr_now    = byte_done & (op_ff == shp_pkg::OP_WRITE) & (idx_ff > shp_pkg::IDX_ADDR_LAST);
  assign in_queue  = (addr_ff[21:12] == shp_pkg::QUEUE_BASE[21:12]);

  // active width latched at select so a write only affects later transfers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      width_ff <= shp_pkg::LANE_WIDTH_RST;
    end else if (cs_fall) begin
      width_ff <= lane_width_ff;
    end
  end

  // byte framing, header decode and address auto-increment
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bitcnt_ff <= 3'h0;
      shift_ff  <= 8'h00;
      idx_ff    <= 3'h0;
      op_ff     <= shp_pkg::OP_READ;
      addr_ff   <= 22'h000000;
    end else if (!sel) begin
      bitcnt_ff <= 3'h0;
      idx_ff    <= 3'h0;
    end else begin
      if (rise) begin
        bitcnt_ff <= cnt_sum[2:0];
        shift_ff  <= nxt_rx;
      end
      if (byte_done) begin
        if (idx_ff < shp_pkg::IDX_DATA) begin
          idx_ff <= idx_ff + 3'h1;
        end
        case (idx_ff)
          3'h0: begin
            op_ff          <= nxt_rx[7:6];
            addr_ff[21:16] <= nxt_rx[5:0];
          end
          3'h1: addr_ff[15:8] <= nxt_rx;
          3'h2: addr_ff[7:0]  <= nxt_rx;
          default: ;
        endcase
      end
      if (wr_now || fetch_ff) begin
        addr_ff <= addr_ff + 22'h1;
      end
    end
  end

  // read prefetch: fetch after the header-complete byte, the dummy byte and each data byte
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fetch_ff    <= 1'b0;
      fetch2_ff   <= 1'b0;
      src_q_ff    <= 1'b0;
      reg_byte_ff <= 8'h00;
      nxt_byte_ff <= 8'h00;
      hold_ff     <= 8'h00;
    end else begin
      fetch_ff  <= byte_done & (op_ff == shp_pkg::OP_READ) & (idx_ff >= shp_pkg::IDX_ADDR_LAST);
      fetch2_ff <= fetch_ff;
      if (fetch_ff) begin
        src_q_ff    <= in_queue;
        reg_byte_ff <= reg_byte;
      end
      if (fetch2_ff) begin
        nxt_byte_ff <= src_q_ff ? rdata_a : reg_byte_ff;
      end
      if (byte_done) begin
        hold_ff <= nxt_byte_ff;
      end
    end
  end

  // transmit shift, updated on falling serial clock, MSB first
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_ff   <= 8'h00;
      pend_ff <= 1'b0;
      out_ff  <= 4'h0;
    end else if (cs_fall) begin
      tx_ff   <= 8'h00;
      pend_ff <= 1'b0;
    end else begin
      if (byte_done) begin
        pend_ff <= 1'b1;
      end else if (fall) begin
        pend_ff <= 1'b0;
        tx_ff   <= (pend_ff ? hold_ff : tx_ff) << step;
        case (width_ff)
          shp_pkg::LANE_DUAL: out_ff <= {2'h0, pend_ff ? hold_ff[7:6] : tx_ff[7:6]};
          shp_pkg::LANE_QUAD: out_ff <= pend_ff ? hold_ff[7:4] : tx_ff[7:4];
          default:            out_ff <= {2'h0, pend_ff ? hold_ff[7] : tx_ff[7], 1'b0};
        endcase
      end
    end
  end

  // lane drivers: MISO whole transfer in single mode, read data phase otherwise
  assign DATA_LANE_OUT = out_ff;
  always_comb begin
    DATA_LANE_OE_N = 4'hf;
    case (width_ff)
      shp_pkg::LANE_DUAL: begin
        if (sel && op_ff == shp_pkg::OP_READ && idx_ff == shp_pkg::IDX_DATA) begin
          DATA_LANE_OE_N = 4'hc;
        end
      end
      shp_pkg::LANE_QUAD: begin
        if (sel && op_ff == shp_pkg::OP_READ && idx_ff == shp_pkg::IDX_DATA) begin
          DATA_LANE_OE_N = 4'h0;
        end
      end
      default: DATA_LANE_OE_N = {2'h3, ~sel, 1'b1};
    endcase
  end

  // register read view
  always_comb begin
    case ({addr_ff[21:2], 2'h0})
      shp_pkg::REG_CMD_READ:   reg_word = {20'h0, cmd_rd_ff};
      shp_pkg::REG_CMD_WRITE:  reg_word = {20'h0, cmd_wr_ff};
      shp_pkg::REG_LANE_WIDTH: reg_word = {30'h0, lane_width_ff};
      shp_pkg::REG_INT_FLAGS:  reg_word = {31'h0, irq_flag_ff};
      default:                 reg_word = 32'h0;
    endcase
    reg_byte = reg_word[8*addr_ff[1:0] +: 8];
  end

  // host register writes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lane_width_ff <= shp_pkg::LANE_WIDTH_RST;
      cmd_wr_ff     <= 12'h000;
    end else if (wr_now) begin
      if (addr_ff == shp_pkg::REG_LANE_WIDTH && nxt_rx[1:0] != shp_pkg::LANE_RSVD) begin
        lane_width_ff <= nxt_rx[1:0];
      end
      if (addr_ff == shp_pkg::REG_CMD_WRITE) begin
        cmd_wr_ff[7:0] <= nxt_rx;
      end
      if (addr_ff == shp_pkg::REG_CMD_WRITE + 22'h1) begin
        cmd_wr_ff[11:8] <= nxt_rx[3:0];
      end
    end
  end

  // host port of the queue memory
  always_comb begin
    req_a.we    = wr_now & in_queue;
    req_a.addr  = addr_ff[11:0];
    req_a.wdata = nxt_rx;
  end

  shp_queue_ram #(
    .AW (shp_pkg::QUEUE_AW)
  ) u_ram (
    .clk     (CLK),
    .rstn    (RSTN),
    .req_a   (req_a),
    .rdata_a (rdata_a),
    .addr_b  (fo_ff + {9'h0, k_ff}),
    .rdata_b (rdata_b)
  );

  assign avail = cmd_wr_ff - cmd_rd_ff;

  // queue engine: fetch a word, decode, run, then retire
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      estate_ff  <= E_IDLE;
      cmd_rd_ff  <= 12'h000;
      fo_ff      <= 12'h000;
      k_ff       <= 3'h0;
      arg_ff     <= 1'b0;
      word_ff    <= 32'h0;
      ms_left_ff <= 32'h0;
      cyc_ff     <= 32'h0;
    end else begin
      case (estate_ff)
        E_IDLE: begin
          if (avail != 12'h000) begin
            fo_ff     <= cmd_rd_ff;
            k_ff      <= 3'h0;
            arg_ff    <= 1'b0;
            estate_ff <= E_FETCH;
          end
        end
        E_FETCH: begin
          k_ff <= k_ff + 3'h1;
          if (k_ff != 3'h0) begin
            word_ff[8*(k_ff-3'h1) +: 8] <= rdata_b;
          end
          if (k_ff == 3'h4) begin
            estate_ff <= arg_ff ? E_WAIT : E_DECODE;
            if (arg_ff) begin
              ms_left_ff <= {word_ff[31:24], word_ff[23:0]};
              ms_left_ff[31:24] <= rdata_b;
              cyc_ff     <= 32'h0;
            end
          end
        end
        E_DECODE: begin
          if (word_ff != shp_pkg::CMD_TIMED_IRQ) begin
            cmd_rd_ff <= cmd_rd_ff + shp_pkg::CMD_BYTES;
            estate_ff <= E_IDLE;
          end else if (avail >= shp_pkg::CMD_ARG_BYTES) begin
            fo_ff     <= cmd_rd_ff + shp_pkg::CMD_BYTES;
            k_ff      <= 3'h0;
            arg_ff    <= 1'b1;
            estate_ff <= E_FETCH;
          end
        end
        E_WAIT: begin
          if (ms_left_ff == 32'h0) begin
            cmd_rd_ff <= cmd_rd_ff + shp_pkg::CMD_ARG_BYTES;
            estate_ff <= E_IDLE;
          end else if (cyc_ff == MS_CYCLES - 1) begin
            cyc_ff     <= 32'h0;
            ms_left_ff <= ms_left_ff - 32'h1;
          end else begin
            cyc_ff <= cyc_ff + 32'h1;
          end
        end
        default: estate_ff <= E_IDLE;
      endcase
    end
  end

  // interrupt flag: set on timer expiry, cleared by reading it; set wins
  assign irq_set = (estate_ff == E_WAIT) && (ms_left_ff == 32'h0);
  assign irq_clr = fetch_ff && !in_queue && (addr_ff == shp_pkg::REG_INT_FLAGS);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_flag_ff <= 1'b0;
    end else if (irq_set) begin
      irq_flag_ff <= 1'b1;
    end else if (irq_clr) begin
      irq_flag_ff <= 1'b0;
    end
  end

  assign INT_N = ~irq_flag_ff;

endmodule // serial_host_port

// *** testbench/shp_host_model.sv ***
// host-side serial master model for the serial host port
// assumes the core clock; pins change only at its falling edge
`timescale 1ns/1ps
module shp_host_model (
  // core clock
  input  wire logic       clk,
  // pins toward the device
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] lane_in,
  input  wire logic [3:0] lane_out,
  input  wire logic [3:0] lane_oe_n
);
  logic [3:0] host_d;
  logic [3:0] host_en;
  logic [3:0] idle_pat = 4'h5;
  logic [7:0] txb [0:15];
  logic [7:0] rxb [0:15];

  // wire level: device when it drives, else host, else a pattern that moves every cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = !lane_oe_n[i] ? lane_out[i] : (host_en[i] ? host_d[i] : idle_pat[i]);
    end
  end

  // undriven lanes never hold a stale value; moves off the sampling edge like every other pin
  always @(negedge clk) idle_pat <= ~idle_pat;

  // idle link: clock parked low, device deselected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    host_d = 4'h0;
    host_en = 4'h0;
  end

  // one framed transfer of n bytes, msb first; lanes released from byte rel on in dual or quad
  task automatic xfer(input logic [1:0] w, input int n, input int rel);
    int bits;
    logic [3:0] m;
    bits = (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
    m = (4'h1 << bits) - 4'h1;
    @(negedge clk);
    cs_n = 1'b0;
    for (int b = 0; b < n; b++) begin
      rxb[b] = 8'h00;
      for (int s = 8 - bits; s >= 0; s -= bits) begin
        host_en = (bits > 1 && b >= rel) ? 4'h0 : m;
        host_d = 4'(txb[b] >> s) & m;
        repeat (4) @(negedge clk); // 160 ns half period, far below the ceilings
        sck = 1'b1;
        rxb[b] = (rxb[b] << bits) | {4'h0, (bits == 1) ? {3'h0, lane_in[1]} : (lane_in & m)};
        repeat (4) @(negedge clk);
        sck = 1'b0;
      end
    end
    host_en = 4'h0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // shp_host_model

// *** testbench/shp_checker.sv ***
// port-level assertions for the serial host port
// assumes binding to serial_host_port, one clock domain
`timescale 1ns/1ps
module shp_checker #(
  parameter int unsigned MS_CYCLES = 20
) (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       SCK,
  input wire logic       CS_N,
  input wire logic [3:0] DATA_LANE_IN,
  input wire logic [3:0] DATA_LANE_OUT,
  input wire logic [3:0] DATA_LANE_OE_N,
  input wire logic       INT_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // lane and interrupt relations
  a_reset_idle_pins: assert property ($rose(RSTN) |-> INT_N && DATA_LANE_OE_N == 4'hf && DATA_LANE_OUT == 4'h0)
    else $error("pins not idle after reset");
  a_idle_released: assert property (CS_N [*6] |-> DATA_LANE_OE_N == 4'hf)
    else $error("lane driven while deselected");
  a_quad_upper_pair: assert property (DATA_LANE_OE_N[3] == DATA_LANE_OE_N[2])
    else $error("upper lanes enabled apart");
  a_quad_all_lanes: assert property (!DATA_LANE_OE_N[2] |-> DATA_LANE_OE_N[1:0] == 2'h0)
    else $error("quad drive without lower lanes");
  a_dual_pair: assert property (!DATA_LANE_OE_N[0] |-> !DATA_LANE_OE_N[1])
    else $error("lane 0 driven without lane 1");
  a_drive_after_select: assert property ($fell(DATA_LANE_OE_N[1]) |-> !$past(CS_N, 2))
    else $error("drive began without select");
  a_out_hold_high: assert property (SCK [*2] |-> $stable(DATA_LANE_OUT))
    else $error("lane data moved while clock high");
  a_irq_clear_xfer: assert property ($rose(INT_N) |-> !$past(CS_N, 3))
    else $error("interrupt cleared outside a transfer");
endmodule // shp_checker

bind serial_host_port shp_checker #(.MS_CYCLES(MS_CYCLES)) chk_i (
  .CLK(CLK), .RSTN(RSTN), .SCK(SCK), .CS_N(CS_N), .DATA_LANE_IN(DATA_LANE_IN),
  .DATA_LANE_OUT(DATA_LANE_OUT), .DATA_LANE_OE_N(DATA_LANE_OE_N), .INT_N(INT_N)
);

// *** testbench/serial_host_port_tb.sv ***
// self-checking bench for the serial host port
// assumes the host model drives the link; short millisecond tick
`timescale 1ns/1ps
module serial_host_port_tb;
  localparam int unsigned MS_SIM = 100;
  localparam int LIMIT = 60000;
  logic        clk;
  logic        rstn;
  logic        sck;
  logic        cs_n;
  logic [3:0]  lane_in;
  logic [3:0]  lane_out;
  logic [3:0]  lane_oe_n;
  logic        int_n;
  logic [1:0]  mode;
  logic [31:0] v;
  logic [31:0] d;
  logic [21:0] a;
  int          err_total;
  int          checks;
  int          cyc;
  int          n;
  int          ms;
  logic [1:0]  codes [0:4] = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h0};

  serial_host_port #(.MS_CYCLES(MS_SIM)) uut (
    .CLK(clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .DATA_LANE_IN(lane_in),
    .DATA_LANE_OUT(lane_out), .DATA_LANE_OE_N(lane_oe_n), .INT_N(int_n)
  );
  shp_host_model host (
    .clk(clk), .sck(sck), .cs_n(cs_n), .lane_in(lane_in), .lane_out(lane_out), .lane_oe_n(lane_oe_n)
  );

  // core clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      err_total++;
      summarize();
    end
  end

  // a reserved width leaves the mode as it was
  function automatic logic [1:0] next_mode(input logic [1:0] cur, input logic [1:0] req);
    return (req == shp_pkg::LANE_RSVD) ? cur : req;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hdr(input logic [1:0] op, input logic [21:0] addr);
    host.txb[0] = {op, addr[21:16]};
    host.txb[1] = addr[15:8];
    host.txb[2] = addr[7:0];
    for (int i = 3; i < 8; i++) host.txb[i] = 8'h00;
  endtask

  task automatic wr(input logic [21:0] addr, input logic [31:0] data, input int nb);
    hdr(shp_pkg::OP_WRITE, addr);
    for (int i = 0; i < nb; i++) host.txb[3+i] = data[8*i +: 8];
    host.xfer(mode, 3 + nb, 16);
  endtask

  task automatic rd(input logic [21:0] addr, input int nb, output logic [31:0] data);
    hdr(shp_pkg::OP_READ, addr);
    host.xfer(mode, 4 + nb, 4);
    data = 32'h0;
    for (int i = 0; i < nb; i++) data[8*i +: 8] = host.rxb[4+i];
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    mode = shp_pkg::LANE_SINGLE;
    err_total = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(32'hdd6f4f0e));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk("int_n idle", 32'h1, {31'h0, int_n});
    rd(shp_pkg::REG_LANE_WIDTH, 1, v);
    chk("width at reset", {30'h0, shp_pkg::LANE_WIDTH_RST}, v);
    // every width code, reserved twice, with queue traffic in each mode
    for (int k = 0; k < 5; k++) begin
      wr(shp_pkg::REG_LANE_WIDTH, {30'h0, codes[k]}, 1);
      mode = next_mode(mode, codes[k]);
      rd(shp_pkg::REG_LANE_WIDTH, 1, v);
      chk("lane width", {30'h0, mode}, v);
      d = $urandom;
      a = shp_pkg::QUEUE_BASE + 22'h400 + 22'($urandom_range(0, 255) * 4);
      wr(a, d, 4);
      rd(a, 4, v);
      chk("queue data", d, v);
    end
    $display("width sweep done");
    // two plain commands retire once the write pointer moves
    wr(shp_pkg::QUEUE_BASE, $urandom & 32'h7fff_ffff, 4);
    wr(shp_pkg::QUEUE_BASE + 22'h4, 32'h0000_0010, 4);
    rd(shp_pkg::REG_CMD_READ, 2, v);
    chk("read ptr empty", 32'h0, v);
    wr(shp_pkg::REG_CMD_WRITE, 32'h8, 2);
    rd(shp_pkg::REG_CMD_READ, 2, v);
    chk("read ptr retired", 32'h8, v);
    wr(shp_pkg::REG_CMD_READ, 32'h0, 2);
    rd(shp_pkg::REG_CMD_READ, 2, v);
    chk("read ptr read only", 32'h8, v);
    $display("queue done");
    // timed interrupt after ms ticks
    ms = $urandom_range(2, 4);
    wr(shp_pkg::QUEUE_BASE + 22'h8, shp_pkg::CMD_TIMED_IRQ, 4);
    wr(shp_pkg::QUEUE_BASE + 22'hc, 32'(ms), 4);
    wr(shp_pkg::REG_CMD_WRITE, 32'h10, 2);
    n = 0;
    while (int_n === 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    // the pointer lands under 80 cycles before the write task returns, so an early interrupt shows
    chk("irq delay", 32'h1, {31'h0, n >= ms * MS_SIM - 80 && n <= ms * MS_SIM});
    chk("int_n asserted", 32'h0, {31'h0, int_n});
    rd(shp_pkg::REG_CMD_READ, 2, v);
    chk("read ptr after irq", 32'h10, v);
    rd(shp_pkg::REG_INT_FLAGS, 1, v);
    chk("irq flag", 32'h1, v);
    chk("int_n cleared", 32'h1, {31'h0, int_n});
    $display("timed interrupt done");
    summarize();
  end
endmodule // serial_host_port_tb
